// >>> logic/host_control_defs.svh
// Constants for the host control register block
`ifndef HOST_CONTROL_DEFS_SVH
`define HOST_CONTROL_DEFS_SVH
`define HC_OFF_HOST_CONTROL 12'h21c
`define HC_IDX_HOST_CONTROL 8'h87
`define HC_OFF_SLEEP_CTRL   12'h220
`define HC_OFF_SEQ_REG      12'h224
`define HC_RESET_VAL        8'h05
`define HC_BIT_SOFT_RESET   0
`define HC_BIT_INT_EN       1
`define HC_BIT_HOLD         2
`define HC_BIT_SPARE        3
`define HC_BIT_SW_INT       4
`define HC_BIT_POWER_DOWN   6
`define HC_WR_MASK          8'h5f
`define HC_ACK_TIMEOUT      8'hff
`endif

// >>> logic/host_control_pkg.sv
// Types for the host control register block
package host_control_pkg;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ACCESS  = 2'b01,
      ST_STRETCH = 2'b10
   } bus_state_t;
endpackage : host_control_pkg

// >>> logic/host_control_power_register.sv
// Host control register with power-down, hold request and APB slave
`timescale 1ns/1ps
`default_nettype none
`include "host_control_defs.svh"
module host_control_power_register
   import host_control_pkg::*;
#(
   parameter int ACK_WAIT = `HC_ACK_TIMEOUT
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        pci_reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sequencer_hold_ack,
   input  wire logic        irq_request,
   output logic             sequencer_hold_req,
   output logic             core_clock_gate_n,
   output logic             pci_clock_gate_n,
   output logic             scsi_input_enable,
   output logic             interrupt_out_a,
   output logic             chip_soft_reset
);
   // Wait counter is eight bits wide, so longer waits cannot be served
   if (ACK_WAIT < 1 || ACK_WAIT > 255) begin : g_bad_wait
      $error("ACK_WAIT out of range");
   end

   // Synchronisers for pins from outside the clock domain
   // Only the second stage is read, so a metastable first stage stays hidden
   logic pr_s1_ff, pr_s2_ff, ack_s1_ff, ack_s2_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pr_s1_ff  <= 1'b0;
         pr_s2_ff  <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
      end else begin
         pr_s1_ff  <= ~pci_reset_n;
         pr_s2_ff  <= pr_s1_ff;
         ack_s1_ff <= sequencer_hold_ack;
         ack_s2_ff <= ack_s1_ff;
      end
   end

   // Bus and register state
   bus_state_t  state_ff, nxt_state;
   logic [7:0]  ctrl_ff, nxt_ctrl;
   logic [1:0]  sleep_ff, nxt_sleep;
   logic [7:0]  seq_ff, nxt_seq;
   logic        pend_ff, nxt_pend;       // Hold bit changed, read must wait
   logic        want_ff, nxt_want;       // Value of hold bit last written
   logic [7:0]  wait_ff, nxt_wait;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready;
   logic        perr_ff, nxt_perr;
   logic        srst_ff, nxt_srst;
   logic        irq_ff, nxt_irq;

   // Address decode and read-back view
   logic        pwr_dn;
   logic        hc_sel, sl_sel, sq_sel, mapped, match;
   logic [7:0]  hc_read, wr_val;
   assign pwr_dn = ctrl_ff[`HC_BIT_POWER_DOWN];
   assign hc_sel = (paddr == `HC_OFF_HOST_CONTROL);
   assign sl_sel = (paddr == `HC_OFF_SLEEP_CTRL);
   assign sq_sel = (paddr == `HC_OFF_SEQ_REG);
   assign mapped = hc_sel | sl_sel | sq_sel;
   // Hold bit reads back the acknowledge, not the request
   assign hc_read = {ctrl_ff[7:3], ack_s2_ff, ctrl_ff[1:0]};
   assign match   = (ack_s2_ff == want_ff);

   // Write value with the power-down interlock applied
   always_comb begin
      wr_val = pwdata[7:0] & `HC_WR_MASK;
      if (pwdata[`HC_BIT_POWER_DOWN] && !pwdata[`HC_BIT_HOLD]) begin
         wr_val[`HC_BIT_POWER_DOWN] = ctrl_ff[`HC_BIT_POWER_DOWN];
      end
   end

   // APB slave, register file and auto access hold sequencing
   always_comb begin
      nxt_state  = state_ff;
      nxt_ctrl   = ctrl_ff;
      nxt_sleep  = sleep_ff;
      nxt_seq    = seq_ff;
      nxt_pend   = pend_ff;
      nxt_want   = want_ff;
      nxt_wait   = wait_ff;
      nxt_prdata = prdata_ff;
      nxt_pready = 1'b0;
      nxt_perr   = 1'b0;
      nxt_srst   = 1'b0;
      nxt_irq    = 1'b0;
      if (pend_ff && match) begin
         nxt_pend = 1'b0;
      end
      unique case (state_ff)
         ST_IDLE: begin
            if (psel && !penable) begin
               nxt_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (pwrite) begin
               // Writes never wait on the acknowledge
               nxt_pready = 1'b1;
               nxt_state  = ST_IDLE;
               if (hc_sel) begin
                  nxt_ctrl  = wr_val;
                  nxt_sleep = 2'b00;
                  if (wr_val[`HC_BIT_HOLD] != ctrl_ff[`HC_BIT_HOLD]) begin
                     nxt_pend = 1'b1;
                  end
                  nxt_want = wr_val[`HC_BIT_HOLD];
                  if (pwdata[`HC_BIT_SOFT_RESET]) begin
                     nxt_ctrl = `HC_RESET_VAL;
                     nxt_srst = 1'b1;
                     nxt_pend = 1'b0;
                     nxt_want = 1'b1;
                  end
               end else if (sl_sel && !pwr_dn) begin
                  nxt_sleep = pwdata[1:0];
               end else if (sq_sel && !pwr_dn && ack_s2_ff) begin
                  nxt_seq = pwdata[7:0];
               end else begin
                  nxt_perr = 1'b1;
               end
            end else if (hc_sel) begin
               // Read stretched in the shared hold timing until matched
               if (!pend_ff || match) begin
                  nxt_prdata = {24'h000000, hc_read};
                  nxt_pready = 1'b1;
                  nxt_state  = ST_IDLE;
               end else begin
                  nxt_state = ST_STRETCH;
                  nxt_wait  = 8'(ACK_WAIT);
               end
            end else if (mapped && !pwr_dn && (sl_sel || ack_s2_ff)) begin
               nxt_prdata = sl_sel ? {30'h0, sleep_ff} : {24'h0, seq_ff};
               nxt_pready = 1'b1;
               nxt_state  = ST_IDLE;
            end else if (sq_sel && !pwr_dn) begin
               // Sequencer-owned register waits in the auto access hold
               nxt_state = ST_STRETCH;
               nxt_wait  = 8'(ACK_WAIT);
            end else begin
               nxt_prdata = 32'h00000000;
               nxt_pready = 1'b1;
               nxt_perr   = 1'b1;
               nxt_state  = ST_IDLE;
            end
         end
         ST_STRETCH: begin
            // Bounded wait so a dead sequencer cannot hang the bus
            nxt_wait = wait_ff - 8'h01;
            if ((hc_sel && match) || (sq_sel && ack_s2_ff) || wait_ff == 8'h00) begin
               nxt_prdata = hc_sel ? {24'h0, hc_read} : {24'h0, seq_ff};
               nxt_perr   = (wait_ff == 8'h00);
               nxt_pready = 1'b1;
               nxt_state  = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (pready_ff) begin
         nxt_pready = 1'b0;
         nxt_perr   = 1'b0;
         nxt_state  = ST_IDLE;
      end
      // Bus reset comes last so it beats a write in the same cycle
      if (pr_s2_ff) begin
         nxt_ctrl  = `HC_RESET_VAL;
         nxt_pend  = 1'b0;
         nxt_want  = 1'b1;
         nxt_sleep = 2'b00;
      end
      // Interrupt follows the next control value so power-down masks it at once
      nxt_irq = irq_request & nxt_ctrl[`HC_BIT_INT_EN] & ~nxt_ctrl[`HC_BIT_POWER_DOWN];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff  <= ST_IDLE;
         ctrl_ff   <= `HC_RESET_VAL;
         sleep_ff  <= 2'b00;
         seq_ff    <= 8'h00;
         pend_ff   <= 1'b0;
         want_ff   <= 1'b1;
         wait_ff   <= 8'h00;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         perr_ff   <= 1'b0;
         srst_ff   <= 1'b0;
         irq_ff    <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         ctrl_ff   <= nxt_ctrl;
         sleep_ff  <= nxt_sleep;
         seq_ff    <= nxt_seq;
         pend_ff   <= nxt_pend;
         want_ff   <= nxt_want;
         wait_ff   <= nxt_wait;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         perr_ff   <= nxt_perr;
         srst_ff   <= nxt_srst;
         irq_ff    <= nxt_irq;
      end
   end

   // Power-down side effects, all from flip-flops
   logic gate_ff, scsi_ff, hold_ff;
   logic nxt_gate, nxt_scsi, nxt_hold;
   // Taken from the next control value so they switch with the register itself
   always_comb begin
      nxt_gate = ~nxt_ctrl[`HC_BIT_POWER_DOWN];
      nxt_scsi = ~nxt_ctrl[`HC_BIT_POWER_DOWN];
      nxt_hold = nxt_ctrl[`HC_BIT_HOLD];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_ff <= 1'b1;
         scsi_ff <= 1'b1;
         hold_ff <= 1'b1;
      end else begin
         gate_ff <= nxt_gate;
         scsi_ff <= nxt_scsi;
         hold_ff <= nxt_hold;
      end
   end

   // Every output is a plain flip-flop
   assign prdata             = prdata_ff;
   assign pready             = pready_ff;
   assign pslverr            = perr_ff;
   assign sequencer_hold_req = hold_ff;
   assign core_clock_gate_n  = gate_ff;
   assign pci_clock_gate_n   = gate_ff;
   assign scsi_input_enable  = scsi_ff;
   assign interrupt_out_a    = irq_ff;
   assign chip_soft_reset    = srst_ff;

   // Power-down effects follow the control register in the same cycle
   a_irq_blocked: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_dn |-> !interrupt_out_a)
      else $error("interrupt raised while powered down");
   a_clk_gated: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_dn |-> !core_clock_gate_n)
      else $error("core clock not gated");
   a_pci_gated: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_dn |-> !pci_clock_gate_n)
      else $error("bus clock not gated");
   a_scsi_iso: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_dn |-> !scsi_input_enable)
      else $error("scsi inputs not isolated");

   // Register bus, interlock and power-down access limits
   a_interlock_pd: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_ACCESS && pwrite && hc_sel && pwdata[6] && !pwdata[2]
       && !pwdata[0] && !pwr_dn && !pr_s2_ff) |=> !pwr_dn)
      else $error("interlock failed");
   a_sleep_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_ACCESS && pwrite && hc_sel) |=> sleep_ff == 2'b00)
      else $error("sleep not cleared");
   a_write_fast: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_ACCESS && pwrite && !pready_ff) |=> pready)
      else $error("write not answered");
   a_pd_restrict: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_ACCESS && (sl_sel || sq_sel) && pwr_dn && !pready_ff) |=> pslverr)
      else $error("access not restricted");

   // Read-back stretching after a hold change and on sequencer register reads
   a_read_match: assert property (@(posedge clk) disable iff (!rst_n)
      (pready && !pwrite && hc_sel && !pslverr && $past(pend_ff))
      |-> prdata[2] == $past(want_ff)) else $error("stretched read mismatch");
   a_stretch_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_STRETCH && hc_sel && !match && wait_ff != 8'h00) |=> !pready)
      else $error("read released before match");
   a_stretch_end: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_STRETCH && hc_sel && match && wait_ff != 8'h00) |=> pready && !pslverr)
      else $error("matched read not released");
   a_seq_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == ST_ACCESS && !pwrite && sq_sel && !pwr_dn && !ack_s2_ff)
      |=> state_ff == ST_STRETCH) else $error("sequencer read not held");

   // Reset values and the hold handshake
   a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
      chip_soft_reset |-> ctrl_ff == `HC_RESET_VAL)
      else $error("soft reset value");
   a_bus_reset: assert property (@(posedge clk) disable iff (!rst_n)
      pr_s2_ff |=> ctrl_ff == `HC_RESET_VAL)
      else $error("bus reset value");
   a_hold_req: assert property (@(posedge clk) disable iff (!rst_n)
      sequencer_hold_req == ctrl_ff[`HC_BIT_HOLD])
      else $error("hold request differs from register");
   a_read_ack: assert property (@(posedge clk) disable iff (!rst_n)
      (pready && !pwrite && hc_sel && !pslverr) |-> prdata[2] == $past(ack_s2_ff))
      else $error("hold bit does not show acknowledge");
endmodule : host_control_power_register
`default_nettype wire

// >>> tb/seq_model.sv
// Sequencer model answering hold requests after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module seq_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic hold_req,
   input  wire logic slow,
   output logic      hold_ack
);
   logic [3:0] cnt_ff;
   // Ack trails the request; slow mode mimics a sequencer busy mid-step
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff   <= 4'h0;
         hold_ack <= 1'b0;
      end else if (hold_req == hold_ack) begin
         cnt_ff <= 4'h0;
      end else if (cnt_ff >= (slow ? 4'h6 : 4'h1)) begin
         hold_ack <= hold_req;
         cnt_ff   <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule : seq_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the host control register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import host_control_pkg::*;
   localparam logic [11:0] HC  = 12'h21c;
   localparam logic [11:0] SLP = 12'h220;
   localparam logic [11:0] SEQ = 12'h224;
   logic        clk, rst_n, pci_reset_n, psel, penable, pwrite, irq, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, ack, req, cg_n, pg_n, scsi_en, irq_a, srst, err;
   logic [7:0]  v;
   int          n_errors, checked, seed, cyc, n_srst, s0;

   host_control_power_register #(.ACK_WAIT(20)) u_dut (.clk(clk), .rst_n(rst_n),
      .pci_reset_n(pci_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sequencer_hold_ack(ack), .irq_request(irq),
      .sequencer_hold_req(req), .core_clock_gate_n(cg_n), .pci_clock_gate_n(pg_n),
      .scsi_input_enable(scsi_en), .interrupt_out_a(irq_a), .chip_soft_reset(srst));
   seq_model u_seq (.clk(clk), .rst_n(rst_n), .hold_req(req), .slow(slow), .hold_ack(ack));

   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Hang guard and soft reset pulse counter
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (srst === 1'b1) n_srst <= n_srst + 1;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic chkb(input string w, input logic e, input logic g);
      chk(w, {31'h0, e}, {31'h0, g});
   endtask : chkb

   // Held until pready is seen high at a rising edge; the task has no time limit of its own beyond the hang guard
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Readback: bits 7,5 zero, bit0 zero unless a reset set it, bit2 mirrors the hold ack
   function automatic logic [31:0] exp_hc(input logic [7:0] w);
      return {24'h0, w & 8'h5e};
   endfunction : exp_hc

   initial begin
      {psel, penable, pwrite, irq, slow, rst_n} = '0;
      {paddr, pwdata, cyc, n_errors, checked, n_srst} = '0;
      pci_reset_n = 1'b1;
      seed = 19;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      chkb("hold_req", 1'b1, req);
      apb(1'b0, HC, 0);
      chk("reset value", 32'h05, rd);
      apb(1'b1, SLP, 32'h3);
      apb(1'b0, SLP, 0);
      chk("sleep written", 32'h3, rd);
      apb(1'b1, HC, 32'h04);
      apb(1'b0, SLP, 0);
      chk("sleep cleared", 32'h0, rd);
      // Slow ack: each read after a hold change is stretched until the ack catches up
      slow <= 1'b1;
      apb(1'b1, HC, 32'h0);
      chkb("hold_req", 1'b0, req);
      apb(1'b0, HC, 0);
      chk("release read", 32'h0, rd);
      chkb("release no error", 1'b0, err);
      apb(1'b1, HC, 32'h14);
      apb(1'b0, HC, 0);
      chk("stretched read", 32'h14, rd);
      chkb("no error", 1'b0, err);
      slow <= 1'b0;
      apb(1'b1, SEQ, 32'ha5);
      apb(1'b0, SEQ, 0);
      chk("seq paused", 32'ha5, rd);
      apb(1'b1, HC, 32'h40);
      apb(1'b0, HC, 0);
      chk("interlock", 32'h0, rd);
      chkb("clock kept", 1'b1, cg_n);
      apb(1'b0, SEQ, 0);
      chkb("seq hold timeout", 1'b1, err);
      for (int i = 0; i < 8; i++) begin
         v = (8'($random(seed)) & 8'h1a) | 8'h04;
         irq <= 1'($random(seed));
         apb(1'b1, HC, {24'h0, v});
         apb(1'b0, HC, 0);
         chk("random rw", exp_hc(v), rd);
         chkb("irq out", irq & v[1], irq_a);
      end
      chk("ack before power down", 32'h04, rd & 32'h04);
      irq <= 1'b1;
      apb(1'b1, HC, 32'h46);
      chkb("core clk", 1'b0, cg_n);
      chkb("pci clk", 1'b0, pg_n);
      chkb("scsi in", 1'b0, scsi_en);
      chkb("irq masked", 1'b0, irq_a);
      apb(1'b0, SEQ, 0);
      chkb("seq refused", 1'b1, err);
      apb(1'b1, SLP, 32'h3);
      chkb("sleep refused", 1'b1, err);
      apb(1'b0, HC, 0);
      chk("host reg open", 32'h46, rd);
      apb(1'b1, HC, 32'h04);
      chkb("clock back", 1'b1, cg_n);
      apb(1'b0, 12'h300, 0);
      chkb("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
      s0 = n_srst;
      apb(1'b1, HC, 32'h1b);
      repeat (3) @(posedge clk);
      chk("soft pulse", 32'd1, 32'(n_srst - s0));
      apb(1'b0, HC, 0);
      chk("soft reset", 32'h05, rd);
      apb(1'b1, HC, 32'h1e);
      pci_reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      pci_reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, HC, 0);
      chk("bus reset", 32'h05, rd);
      summarize();
   end
endmodule : tb
`default_nettype wire
